// ===== verilog/iep_top.sv
// iep_top: interrupt enable and priority logic with Avalon-MM register slave
// assumes: peripheral event inputs are one-cycle pulses synchronous to CORE_CLK,
// SUPPLY_LOW is a synchronous level from the supply monitor
//
// Overview of operation
// [RL1] timer2 enable bit 5 passes overflow or external flag request; clear masks both
// [RL2] uart enable bit 4 passes transmit-done or receive-done request; clear masks them
// [RL3] timer1 enable bit 3 passes timer1 overflow request; clear masks it
// [RL4] external pin1 enable bit 2 passes pin1 request; clear masks it
// [RL5] timer0 enable bit 1 passes timer0 overflow request; clear masks it
// [RL6] external pin0 enable bit 0 passes pin0 request; clear masks it
// [RL7] extended enable bit 2 passes supply-drop flag request; clear masks it
// [RL8] extended enable bit 1 passes wake timer flag request; clear masks it
// [RL9] extended enable bit 0 passes serial done, overrun or conflict request
// [RL10] priority register bit 5 holds timer2 priority low bit beside other sources
// [RL11] byte completing while previous unread or done set sets overrun flag
// [RL12] drop reset select zero: supply drop sets flag, requests interrupt, no reset
// [RL13] cleared drop flag stays clear while low, sets again on recovery
// [RL14] serial request reaches core only with source and global enable set
// [RL15] flag set while disabled stays pending and requests once enabled
`timescale 1ns/100ps
module iep_top
   import iep_pkg::*;
(
   input  wire logic        CORE_CLK,
   input  wire logic        RESETN,
   input  wire logic [7:0]  AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic      [31:0] AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   input  wire logic        T2_OVF_EVT,
   input  wire logic        T2_EXT_EVT,
   input  wire logic        UART_TX_EVT,
   input  wire logic        UART_RX_EVT,
   input  wire logic        T1_OVF_EVT,
   input  wire logic        T0_OVF_EVT,
   input  wire logic        EXT_PIN1_REQUEST,
   input  wire logic        EXT_PIN0_REQUEST,
   input  wire logic        WAKE_TIMER_EVT,
   input  wire logic        SPI_XFER_EVT,
   input  wire logic        SPI_BUF_READ,
   input  wire logic        SPI_CONFLICT_EVT,
   input  wire logic        SUPPLY_LOW,
   output logic      [8:0]  CORE_REQ,
   output logic      [5:0]  CORE_PRIORITY,
   output logic             CORE_RESET_REQ,
   output logic             IRQ
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic [7:0]           base_en_reg;
   logic [7:0]           prio_reg;
   logic [7:0]           ext_en_reg;
   logic [7:0]           ctrl_reg;
   logic [NUM_FLAGS-1:0] mask_reg;
   logic [NUM_FLAGS-1:0] flags_reg;
   logic [NUM_FLAGS-1:0] flags_set;
   logic [NUM_FLAGS-1:0] flags_clr;
   logic                 ack_reg;
   logic                 unread_reg;
   logic                 supply_prev_reg;
   logic                 bus_req;
   logic                 wr_fire;
   logic                 rx_overrun;
   logic                 supply_edge;
   logic [31:0]          rdata_next;
   iep_gate_if           gif ();

   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);

   // ---------------------------------------------------------------
   // bus handshake: one wait cycle, then the transfer completes
   // ---------------------------------------------------------------
   assign bus_req = AVS_READ | AVS_WRITE;
   assign wr_fire = AVS_WRITE & ack_reg & AVS_BYTEENABLE[0];

   // ack rises one cycle after the request, waitrequest drops with it
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ack_reg         <= 1'b0;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         ack_reg         <= bus_req & ~ack_reg;
         AVS_WAITREQUEST <= ~(bus_req & ~ack_reg);
      end
   end

   // read data mux; unmapped indexes read zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (AVS_ADDRESS)
         BASE_EN_IDX: rdata_next[7:0] = base_en_reg;
         PRIO_IDX:    rdata_next[7:0] = prio_reg;
         EXT_EN_IDX:  rdata_next[7:0] = ext_en_reg;
         CTRL_IDX:    rdata_next[7:0] = ctrl_reg;
         STATUS_IDX:  rdata_next[NUM_FLAGS-1:0] = flags_reg;
         MASK_IDX:    rdata_next[NUM_FLAGS-1:0] = mask_reg;
         default:     rdata_next = 32'h0000_0000;
      endcase
   end

   // read data captured as waitrequest falls, stands at the completing edge
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (AVS_READ & ~ack_reg) begin
         AVS_READDATA <= rdata_next;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   // enables, priority, control and mask; reserved bits stay zero
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         base_en_reg <= BASE_EN_RST;
         prio_reg    <= PRIO_RST;
         ext_en_reg  <= EXT_EN_RST;
         ctrl_reg    <= CTRL_RST;
         mask_reg    <= MASK_RST;
      end else if (wr_fire) begin
         case (AVS_ADDRESS)
            BASE_EN_IDX: base_en_reg <= AVS_WRITEDATA[7:0] & BASE_EN_WMASK;
            PRIO_IDX:    prio_reg    <= AVS_WRITEDATA[7:0] & PRIO_WMASK; // RL10
            EXT_EN_IDX:  ext_en_reg  <= AVS_WRITEDATA[7:0] & EXT_EN_WMASK;
            CTRL_IDX:    ctrl_reg    <= AVS_WRITEDATA[7:0] & CTRL_WMASK;
            MASK_IDX:    mask_reg    <= AVS_WRITEDATA[NUM_FLAGS-1:0];
            default:     ctrl_reg    <= ctrl_reg;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // serial receive overrun and supply-drop event detection
   // ---------------------------------------------------------------
   // a byte finishing before the previous one was read is an overrun
   assign rx_overrun  = SPI_XFER_EVT & (unread_reg | flags_reg[FLG_XFER]); // RL11
   // both the drop and the recovery are edges of the supply level
   assign supply_edge = SUPPLY_LOW ^ supply_prev_reg; // RL13

   // unread byte tracker and supply level history
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         unread_reg      <= 1'b0;
         supply_prev_reg <= 1'b0;
      end else begin
         unread_reg      <= (SPI_XFER_EVT & ~rx_overrun) | (unread_reg & ~SPI_BUF_READ);
         supply_prev_reg <= SUPPLY_LOW;
      end
   end

   // reset request instead of the flag when drop reset is selected
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         CORE_RESET_REQ <= 1'b0;
      end else begin
         CORE_RESET_REQ <= SUPPLY_LOW & ctrl_reg[DROP_RST_SEL_BIT]; // RL12
      end
   end

   // ---------------------------------------------------------------
   // sticky flags: set by events, cleared by writing one, set wins
   // ---------------------------------------------------------------
   always_comb begin
      flags_set               = '0;
      flags_set[FLG_EXT0]     = EXT_PIN0_REQUEST;
      flags_set[FLG_T0_OVF]   = T0_OVF_EVT;
      flags_set[FLG_EXT1]     = EXT_PIN1_REQUEST;
      flags_set[FLG_T1_OVF]   = T1_OVF_EVT;
      flags_set[FLG_UART_RX]  = UART_RX_EVT;
      flags_set[FLG_UART_TX]  = UART_TX_EVT;
      flags_set[FLG_T2_OVF]   = T2_OVF_EVT;
      flags_set[FLG_T2_EXT]   = T2_EXT_EVT;
      flags_set[FLG_XFER]     = SPI_XFER_EVT & ~rx_overrun;
      flags_set[FLG_OVERRUN]  = rx_overrun; // RL11
      flags_set[FLG_CONFLICT] = SPI_CONFLICT_EVT;
      flags_set[FLG_WAKE]     = WAKE_TIMER_EVT;
      flags_set[FLG_DROP]     = supply_edge & ~ctrl_reg[DROP_RST_SEL_BIT]; // RL12
   end

   assign flags_clr = (wr_fire && AVS_ADDRESS == STATUS_IDX) ?
                      AVS_WRITEDATA[NUM_FLAGS-1:0] : '0;

   // flags stay pending whatever the enables say
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         flags_reg <= FLAGS_RST;
      end else begin
         flags_reg <= (flags_reg & ~flags_clr) | flags_set; // RL15
      end
   end

   // ---------------------------------------------------------------
   // request gating toward the processor core
   // ---------------------------------------------------------------
   assign gif.pending[SRC_EXT0] = flags_reg[FLG_EXT0]; // RL6
   assign gif.pending[SRC_T0]   = flags_reg[FLG_T0_OVF]; // RL5
   assign gif.pending[SRC_EXT1] = flags_reg[FLG_EXT1]; // RL4
   assign gif.pending[SRC_T1]   = flags_reg[FLG_T1_OVF]; // RL3
   assign gif.pending[SRC_UART] = flags_reg[FLG_UART_RX] | flags_reg[FLG_UART_TX]; // RL2
   assign gif.pending[SRC_T2]   = flags_reg[FLG_T2_OVF] | flags_reg[FLG_T2_EXT]; // RL1
   assign gif.pending[SRC_SPI]  = |flags_reg[FLG_CONFLICT:FLG_XFER]; // RL9
   assign gif.pending[SRC_WAKE] = flags_reg[FLG_WAKE]; // RL8
   assign gif.pending[SRC_DROP] = flags_reg[FLG_DROP]; // RL7
   assign gif.enable            = {ext_en_reg[2:0], base_en_reg[5:0]};
   assign gif.global_en         = base_en_reg[GLOBAL_EN_BIT]; // RL14

   iep_gate u_gate (
      .gif (gif.gate)
   );

   // registered requests, priority bits and summary interrupt
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         CORE_REQ      <= '0;
         CORE_PRIORITY <= '0;
         IRQ           <= 1'b0;
      end else begin
         CORE_REQ      <= gif.req;
         CORE_PRIORITY <= prio_reg[5:0]; // RL10
         IRQ           <= |(flags_reg & mask_reg);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   chk_t2_pass: assert property ( // RL1
      (base_en_reg[SRC_T2] && gif.global_en && gif.pending[SRC_T2]) |=> CORE_REQ[SRC_T2])
      else $error("timer2 request not passed");
   chk_t2_mask: assert property ( // RL1
      !base_en_reg[SRC_T2] |=> !CORE_REQ[SRC_T2])
      else $error("timer2 request not masked");
   chk_uart_pass: assert property ( // RL2
      (base_en_reg[SRC_UART] && gif.global_en && $rose(flags_reg[FLG_UART_TX]))
      |=> CORE_REQ[SRC_UART])
      else $error("uart transmit request not passed");
   chk_t1_gate: assert property ( // RL3
      CORE_REQ[SRC_T1] == $past(base_en_reg[SRC_T1] && gif.global_en && flags_reg[FLG_T1_OVF]))
      else $error("timer1 request wrong");
   chk_drop_mask: assert property ( // RL7
      !ext_en_reg[0+2] |=> !CORE_REQ[SRC_DROP])
      else $error("supply drop request not masked");
   chk_wake_pass: assert property ( // RL8
      (ext_en_reg[1] && gif.global_en && flags_reg[FLG_WAKE]) |=> CORE_REQ[SRC_WAKE])
      else $error("wake timer request not passed");
   chk_spi_ovr_req: assert property ( // RL9
      (ext_en_reg[0] && gif.global_en && flags_reg[FLG_OVERRUN]) |=> CORE_REQ[SRC_SPI])
      else $error("serial overrun request not passed");
   chk_global_off: assert property ( // RL14
      !gif.global_en |=> CORE_REQ == 9'h000)
      else $error("request passed with master enable off");
   chk_overrun_set: assert property ( // RL11
      (SPI_XFER_EVT && flags_reg[FLG_XFER]) |=> flags_reg[FLG_OVERRUN] && flags_reg[FLG_XFER])
      else $error("overrun flag not set");
   chk_drop_set: assert property ( // RL12
      ($rose(SUPPLY_LOW) && !ctrl_reg[DROP_RST_SEL_BIT]) |=> flags_reg[FLG_DROP] ##1 !CORE_RESET_REQ)
      else $error("supply drop did not set flag");
   chk_drop_quiet: assert property ( // RL13
      (!flags_reg[FLG_DROP] && supply_prev_reg && SUPPLY_LOW) |=> !flags_reg[FLG_DROP])
      else $error("supply drop flag set again while low");
   chk_pending_kept: assert property ( // RL15
      ($rose(base_en_reg[SRC_T0]) && gif.global_en && flags_reg[FLG_T0_OVF])
      |=> CORE_REQ[SRC_T0])
      else $error("pending flag lost while disabled");
   chk_uart_rx_pass: assert property ( // RL2
      (base_en_reg[SRC_UART] && gif.global_en && flags_reg[FLG_UART_RX]) |=> CORE_REQ[SRC_UART])
      else $error("uart receive request not passed");
   chk_ext1_gate: assert property ( // RL4
      CORE_REQ[SRC_EXT1] == $past(base_en_reg[SRC_EXT1] && gif.global_en && flags_reg[FLG_EXT1]))
      else $error("pin1 request wrong");
   chk_t0_gate: assert property ( // RL5
      CORE_REQ[SRC_T0] == $past(base_en_reg[SRC_T0] && gif.global_en && flags_reg[FLG_T0_OVF]))
      else $error("timer0 request wrong");
   chk_ext0_gate: assert property ( // RL6
      CORE_REQ[SRC_EXT0] == $past(base_en_reg[SRC_EXT0] && gif.global_en && flags_reg[FLG_EXT0]))
      else $error("pin0 request wrong");
   chk_prio_copy: assert property ( // RL10
      CORE_PRIORITY == $past(prio_reg[5:0]))
      else $error("priority bits not passed to core");
   chk_irq_level: assert property (
      IRQ == $past(|(flags_reg & mask_reg)))
      else $error("summary interrupt wrong");
   chk_drop_recover: assert property ( // RL13
      ($fell(SUPPLY_LOW) && supply_prev_reg && !ctrl_reg[DROP_RST_SEL_BIT]) |=> flags_reg[FLG_DROP])
      else $error("supply recovery did not set flag");
   chk_bus_wait: assert property (
      ($rose(bus_req) && AVS_WAITREQUEST) |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
      else $error("bus answer not after one wait cycle");

   cov_overrun: cover property (SPI_XFER_EVT && flags_reg[FLG_XFER]);
   cov_drop_recover: cover property ($fell(SUPPLY_LOW) && !ctrl_reg[DROP_RST_SEL_BIT]);
   cov_late_enable: cover property ($rose(base_en_reg[SRC_T2]) && flags_reg[FLG_T2_OVF]);
   cov_set_clear: cover property (|(flags_set & flags_clr));

endmodule // iep_top

// ===== verilog/iep_pkg.sv
// iep_pkg: constants shared by the interrupt enable and priority block
// assumes: word-addressed Avalon-MM slave, register index equals word address
package iep_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned NUM_FLAGS = 13;  // sticky source flags
   localparam int unsigned NUM_SRC   = 9;   // gated request lines to the core

   // ---------------------------------------------------------------
   // register indexes (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [7:0] BASE_EN_IDX = 8'ha8;
   localparam logic [7:0] PRIO_IDX    = 8'hb8;
   localparam logic [7:0] EXT_EN_IDX  = 8'hbd;
   localparam logic [7:0] STATUS_IDX  = 8'hc0;
   localparam logic [7:0] MASK_IDX    = 8'hc1;
   localparam logic [7:0] CTRL_IDX    = 8'hc2;

   // ---------------------------------------------------------------
   // reset values and writable bits
   // ---------------------------------------------------------------
   localparam logic [7:0]           BASE_EN_RST   = 8'h00;
   localparam logic [7:0]           PRIO_RST      = 8'h00;
   localparam logic [7:0]           EXT_EN_RST    = 8'h00;
   localparam logic [7:0]           CTRL_RST      = 8'h00;
   localparam logic [NUM_FLAGS-1:0] MASK_RST      = 13'h0000;
   localparam logic [NUM_FLAGS-1:0] FLAGS_RST     = 13'h0000;
   localparam logic [7:0]           BASE_EN_WMASK = 8'hbf;  // bit 6 reserved
   localparam logic [7:0]           PRIO_WMASK    = 8'h3f;  // bits 7:6 read zero
   localparam logic [7:0]           EXT_EN_WMASK  = 8'h07;  // bits 7:3 reserved
   localparam logic [7:0]           CTRL_WMASK    = 8'h01;

   // ---------------------------------------------------------------
   // field positions
   // ---------------------------------------------------------------
   localparam int unsigned GLOBAL_EN_BIT    = 7;  // base enable register
   localparam int unsigned DROP_RST_SEL_BIT = 0;  // control register
   localparam int unsigned TIMER2_PRIO_BIT  = 5;  // priority register

   // sticky flag positions in status and mask registers
   localparam int unsigned FLG_EXT0     = 0;
   localparam int unsigned FLG_T0_OVF   = 1;
   localparam int unsigned FLG_EXT1     = 2;
   localparam int unsigned FLG_T1_OVF   = 3;
   localparam int unsigned FLG_UART_RX  = 4;
   localparam int unsigned FLG_UART_TX  = 5;
   localparam int unsigned FLG_T2_OVF   = 6;
   localparam int unsigned FLG_T2_EXT   = 7;
   localparam int unsigned FLG_XFER     = 8;
   localparam int unsigned FLG_OVERRUN  = 9;
   localparam int unsigned FLG_CONFLICT = 10;
   localparam int unsigned FLG_WAKE     = 11;
   localparam int unsigned FLG_DROP     = 12;

   // request line order; first six match base enable bits, rest extended+6
   localparam int unsigned SRC_EXT0  = 0;
   localparam int unsigned SRC_T0    = 1;
   localparam int unsigned SRC_EXT1  = 2;
   localparam int unsigned SRC_T1    = 3;
   localparam int unsigned SRC_UART  = 4;
   localparam int unsigned SRC_T2    = 5;
   localparam int unsigned SRC_SPI   = 6;
   localparam int unsigned SRC_WAKE  = 7;
   localparam int unsigned SRC_DROP  = 8;

endpackage

// ===== verilog/iep_gate_if.sv
// iep_gate_if: pending groups, enables and gated requests between modules
// assumes: one clock domain, driven by the top module
`timescale 1ns/100ps
interface iep_gate_if;
   logic [8:0] pending;    // per-request pending group
   logic [8:0] enable;     // per-request enable bit
   logic       global_en;  // master enable
   logic [8:0] req;        // gated requests

   modport ctrl (output pending, output enable, output global_en, input req);
   modport gate (input pending, input enable, input global_en, output req);
endinterface // iep_gate_if

// ===== verilog/iep_gate.sv
// iep_gate: combines pending groups with source and master enables
// assumes: inputs come from registers of the top module
`timescale 1ns/100ps
module iep_gate
   import iep_pkg::*;
(
   iep_gate_if.gate gif
);

   // ---------------------------------------------------------------
   // per-request gating
   // ---------------------------------------------------------------
   // a request passes only with its enable and the master enable set
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign gif.req[i] = gif.global_en & gif.enable[i] & gif.pending[i]; // RL14
   end

endmodule // iep_gate

// ===== sim/iep_core_model.sv
// iep_core_model: behavioural core that picks the request it would serve
// assumes: CORE_REQ and CORE_PRIORITY come registered from the block
`timescale 1ns/100ps
module iep_core_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic [8:0] req,
   input  wire logic [5:0] prio,
   output logic            take_vld,
   output logic      [3:0] take_idx
);
   // high level lines win, then the lowest line number; lines 6..8 stay low level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         take_vld <= 1'b0;
         take_idx <= 4'h0;
      end else begin
         take_vld <= |req;
         for (int i = 8; i >= 0; i--) begin
            if (req[i]) take_idx <= 4'(i);
         end
         for (int i = 5; i >= 0; i--) begin
            if (req[i] && prio[i]) take_idx <= 4'(i);
         end
      end
   end
endmodule // iep_core_model

// ===== sim/interrupt_enable_priority_tb.sv
// interrupt_enable_priority_tb: self-checking bench for iep_top
// assumes: iep_pkg register map, one wait edge per bus transfer
`timescale 1ns/100ps
module interrupt_enable_priority_tb;
   import iep_pkg::*;
   logic        core_clk, resetn, rd, wr, spi_rd, sup_low, core_rst, irq, take_vld;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, q;
   logic [3:0]  be, take_idx;
   logic        waitreq;
   logic [12:0] evt;
   logic [8:0]  core_req;
   logic [5:0]  core_prio;
   int          fail_count, checks;
   logic [7:0]  ridx [5] = '{BASE_EN_IDX, PRIO_IDX, EXT_EN_IDX, MASK_IDX, CTRL_IDX};
   logic [31:0] rmsk [5] = '{32'(BASE_EN_WMASK), 32'(PRIO_WMASK), 32'(EXT_EN_WMASK),
                             32'h0000_1fff, 32'(CTRL_WMASK)};

   // ---------------------------------------------------------------
   // design and core model
   // ---------------------------------------------------------------
   iep_top u_iep_top (.CORE_CLK(core_clk), .RESETN(resetn), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be),
      .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .T2_OVF_EVT(evt[FLG_T2_OVF]),
      .T2_EXT_EVT(evt[FLG_T2_EXT]), .UART_TX_EVT(evt[FLG_UART_TX]),
      .UART_RX_EVT(evt[FLG_UART_RX]), .T1_OVF_EVT(evt[FLG_T1_OVF]),
      .T0_OVF_EVT(evt[FLG_T0_OVF]), .EXT_PIN1_REQUEST(evt[FLG_EXT1]),
      .EXT_PIN0_REQUEST(evt[FLG_EXT0]), .WAKE_TIMER_EVT(evt[FLG_WAKE]),
      .SPI_XFER_EVT(evt[FLG_XFER]), .SPI_BUF_READ(spi_rd),
      .SPI_CONFLICT_EVT(evt[FLG_CONFLICT]), .SUPPLY_LOW(sup_low), .CORE_REQ(core_req),
      .CORE_PRIORITY(core_prio), .CORE_RESET_REQ(core_rst), .IRQ(irq));
   iep_core_model u_iep_core_model (.clk(core_clk), .rst_n(resetn), .req(core_req),
      .prio(core_prio), .take_vld(take_vld), .take_idx(take_idx));

   // ---------------------------------------------------------------
   // tasks and expectation helpers
   // ---------------------------------------------------------------
   // one bus transfer, held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr <= w;
      rd <= !w;
      // only the watchdog ends a wait that never gets its answer
      do begin
         @(posedge core_clk);
      end while (waitreq !== 1'b0);
      q = rdata;
      wr <= 1'b0;
      rd <= 1'b0;
   endtask
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
      bus(1'b0, a, 32'h0000_0000);
      cmp(nm, exp, q);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one-cycle event pulse on flag input f
   task automatic pulse(input int f);
      @(posedge core_clk);
      evt <= 13'(1) << f;
      @(posedge core_clk);
      evt <= '0;
   endtask
   task automatic spi_read();
      @(posedge core_clk);
      spi_rd <= 1'b1;
      @(posedge core_clk);
      spi_rd <= 1'b0;
   endtask
   // request line fed by each sticky flag
   function automatic int src_of(input int f);
      case (f)
         4, 5: return 4;
         6, 7: return 5;
         8, 9, 10: return 6;
         11: return 7;
         12: return 8;
         default: return f;
      endcase
   endfunction
   task automatic stop_test();
      if (fail_count == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end
   initial begin
      int s;
      logic [31:0] d, en;
      {resetn, rd, wr, spi_rd, sup_low, addr, wdata, evt} = '0;
      be = 4'hf;
      fail_count = 0;
      checks = 0;
      void'($urandom(32'h7a6e8836));
      tick(5);
      resetn <= 1'b1;
      cmp("reset_out", 32'h0000_0000, 32'({core_req, core_prio, core_rst, irq}));
      // reset values, random read-back, unmapped and byte-disabled writes
      for (int i = 0; i < 5; i++) rchk(ridx[i], 32'h0000_0000, "reset_reg");
      rchk(STATUS_IDX, 32'h0000_0000, "reset_status");
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 5; i++) begin
            d = $urandom;
            wreg(ridx[i], d);
            rchk(ridx[i], d & rmsk[i], "reg_rw");
            if (i == 1) cmp("core_prio", 32'(d[5:0]), 32'(core_prio));
         end
      end
      for (int i = 0; i < 5; i++) wreg(ridx[i], 32'h0000_0000);
      wreg(8'ha9, 32'h0000_00ff);
      rchk(8'ha9, 32'h0000_0000, "unmapped");
      be <= 4'h0;
      wreg(PRIO_IDX, 32'h0000_003f);
      be <= 4'hf;
      rchk(PRIO_IDX, 32'h0000_0000, "byte_off");
      // every flag except overrun and supply drop: pending while disabled, passed when enabled, global gate, mask, clear
      for (int f = 0; f < NUM_FLAGS; f++) begin
         if (f == FLG_OVERRUN || f == FLG_DROP) continue;
         s = src_of(f);
         en = (s < 6) ? (32'h0000_0080 | (32'h1 << s)) : (32'h1 << (s - 6));
         wreg(BASE_EN_IDX, 32'h0000_0080);
         pulse(f);
         tick(2);
         rchk(STATUS_IDX, 32'h1 << f, "status_set");
         cmp("req_masked", 32'h0000_0000, 32'(core_req));
         wreg((s < 6) ? BASE_EN_IDX : EXT_EN_IDX, en);
         tick(2);
         cmp("req_on", 32'h1 << s, 32'(core_req));
         tick(1);
         cmp("core_take", 32'(s) | 32'h10, 32'({take_vld, take_idx}));
         cmp("irq_masked", 32'h0000_0000, 32'(irq));
         wreg(MASK_IDX, 32'h1 << f);
         tick(2);
         cmp("irq_on", 32'h0000_0001, 32'(irq));
         wreg(BASE_EN_IDX, en & 32'h0000_007f);
         tick(2);
         cmp("req_global_off", 32'h0000_0000, 32'(core_req));
         wreg(STATUS_IDX, 32'h1 << f);
         spi_read();
         tick(2);
         cmp("irq_clr", 32'h0000_0000, 32'(irq));
         rchk(STATUS_IDX, 32'h0000_0000, "status_clr");
         wreg(MASK_IDX, 32'h0000_0000);
         wreg(EXT_EN_IDX, 32'h0000_0000);
      end
      // serial overrun, then a properly read byte
      wreg(BASE_EN_IDX, 32'h0000_0080);
      wreg(EXT_EN_IDX, 32'h0000_0001);
      pulse(FLG_XFER);
      pulse(FLG_XFER);
      tick(2);
      rchk(STATUS_IDX, 32'h0000_0300, "overrun");
      cmp("req_spi", 32'h0000_0040, 32'(core_req));
      wreg(STATUS_IDX, 32'h0000_0300);
      spi_read();
      pulse(FLG_XFER);
      spi_read();
      wreg(STATUS_IDX, 32'h0000_0100);
      pulse(FLG_XFER);
      tick(2);
      rchk(STATUS_IDX, 32'h0000_0100, "no_overrun");
      wreg(STATUS_IDX, 32'h0000_0100);
      spi_read();
      // supply drop as interrupt, no re-set while low, recovery, reset select
      wreg(EXT_EN_IDX, 32'h0000_0004);
      sup_low <= 1'b1;
      tick(2);
      rchk(STATUS_IDX, 32'h0000_1000, "drop_set");
      cmp("drop_req", 32'h0000_0100, 32'(core_req));
      cmp("no_reset", 32'h0000_0000, 32'(core_rst));
      wreg(STATUS_IDX, 32'h0000_1000);
      tick(4);
      rchk(STATUS_IDX, 32'h0000_0000, "drop_quiet");
      cmp("drop_masked", 32'h0000_0000, 32'(core_req));
      sup_low <= 1'b0;
      tick(2);
      rchk(STATUS_IDX, 32'h0000_1000, "drop_recover");
      wreg(STATUS_IDX, 32'h0000_1000);
      wreg(CTRL_IDX, 32'h0000_0001);
      sup_low <= 1'b1;
      tick(2);
      cmp("drop_reset", 32'h0000_0001, 32'(core_rst));
      sup_low <= 1'b0;
      wreg(CTRL_IDX, 32'h0000_0000);
      wreg(EXT_EN_IDX, 32'h0000_0000);
      wreg(STATUS_IDX, 32'h0000_1fff);
      // priority bit of timer 2 steers the core's choice
      wreg(BASE_EN_IDX, 32'h0000_00a2);
      pulse(FLG_T0_OVF);
      pulse(FLG_T2_OVF);
      wreg(PRIO_IDX, 32'h0000_0020);
      tick(3);
      cmp("take_t2", 32'h0000_0005, 32'(take_idx));
      wreg(PRIO_IDX, 32'h0000_0000);
      tick(3);
      cmp("take_t0", 32'h0000_0001, 32'(take_idx));
      stop_test();
   end
endmodule // interrupt_enable_priority_tb
